// *** shared/ssp_pkg.sv ***
/*
  Package for the serial slave port: frame layout, CRC defaults, register
  write request struct. Assumes a single system clock domain of 25 MHz.
*/
package ssp_pkg;
  localparam int FRAME_BITS   = 16;   // Minimum frame length
  localparam int CRC_BITS     = 4;    // CRC tail length
  localparam int EXT_BITS     = 20;   // Frame length with CRC
  localparam int POS_SYNC     = 15;   // Sync bit position in 16-bit word
  localparam int POS_RW       = 14;   // Read/write bit position
  localparam int POS_ADDR_HI  = 13;   // Address field top bit
  localparam int POS_ADDR_LO  = 8;    // Address field bottom bit
  localparam int POS_DATA_HI  = 7;    // Data field top bit
  localparam int CRC_ERR_BIT  = 8;    // CRC error flag in error register
  localparam logic [5:0] ERR_REG_ADDR  = 6'h24; // Error register byte address
  localparam logic [3:0] CRC_POLY_DEF  = 4'h3;  // Generator x^4+x+1, arbitrary
  localparam logic [3:0] CRC_SEED_DEF  = 4'hf;  // CRC seed, arbitrary
  localparam logic [15:0] MISO_RESET   = 16'h0000; // No read seen yet

  // Write request to the register bank
  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic [7:0] data;
  } ssp_wr_t;
endpackage : ssp_pkg

// *** hdl/ssp_crc4.sv ***
/*
  Serial 4-bit CRC engine, one bit per step, polynomial and seed as inputs.
  Assumes the caller steps it once per shifted bit, MSB first.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_crc4 (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Control
  input  wire logic       init,
  input  wire logic       step,
  input  wire logic       bitIn,
  input  wire logic [3:0] poly,
  input  wire logic [3:0] seed,
  // Result
  output logic [3:0]      crc
);
  logic fb;
  assign fb = crc[3] ^ bitIn;

  // LFSR update, init wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      crc <= 4'h0;
    end else if (init) begin
      crc <= seed;
    end else if (step) begin
      crc <= {crc[2:0], 1'b0} ^ (fb ? poly : 4'h0);
    end
  end
endmodule : ssp_crc4
`default_nettype wire

// *** hdl/ssp_spi_slave.sv ***
/*
  SPI mode 3 slave port of the sensor: 16-bit frames, 20 with CRC.
  Assumes SCLK, MOSI, CS_n arrive asynchronously and are sampled by sys_clk
  (SCLK well below sys_clk/4). Register storage lives outside; reads are
  combinational from rdData.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_spi_slave
  import ssp_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // Pins
  input  wire logic        interface_select_pin,
  input  wire logic        sclkPin,
  input  wire logic        mosiPin,
  input  wire logic        csPin_n,
  output logic             misoOut,
  output logic             misoOe,
  // Configuration
  input  wire logic        spi_crc_check_enable,
  input  wire logic [3:0]  crcPoly,
  input  wire logic [3:0]  crcSeed,
  // Register bank
  output logic [5:0]       rdAddr,
  input  wire logic [15:0] rdData,
  output ssp_wr_t          wrReq,
  output logic             crcErrSet
);
  logic [1:0] selS, sclkS, mosiS, csS;
  logic       sclkD, csD;
  logic [4:0] bitCnt;
  logic [19:0] rxShift;
  logic [19:0] txShift;
  logic [15:0] frameTx;
  logic [5:0]  rdAddrHold;
  logic        haveRead;
  logic        active, rise, fall, csFall, csRise;
  logic [3:0]  txCrc, rxCrc;

  // Two-flop synchronisers on every pin input
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      selS  <= 2'h0;
      sclkS <= 2'h3;
      mosiS <= 2'h0;
      csS   <= 2'h3;
    end else begin
      selS  <= {selS[0], interface_select_pin};
      sclkS <= {sclkS[0], sclkPin};
      mosiS <= {mosiS[0], mosiPin};
      csS   <= {csS[0], csPin_n};
    end
  end

  // Edge history of synchronised levels
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkD <= 1'b1;
      csD   <= 1'b1;
    end else begin
      sclkD <= sclkS[1];
      csD   <= csS[1];
    end
  end

  assign active = selS[1];
  // mode 3 edges inside a frame
  assign rise   = active && !csS[1] && sclkS[1] && !sclkD;
  assign fall   = active && !csS[1] && !sclkS[1] && sclkD;
  assign csFall = active && !csS[1] && csD;
  assign csRise = active && csS[1] && !csD;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxShift <= 20'h00000;
      bitCnt  <= 5'h00;
    end else if (csFall) begin
      rxShift <= 20'h00000;
      bitCnt  <= 5'h00;
    end else if (rise) begin
      rxShift <= {rxShift[18:0], mosiS[1]};
      if (bitCnt != 5'd31) begin
        bitCnt <= bitCnt + 5'd1;
      end
    end
  end

  // odd address gives single byte, upper zero
  assign rdAddr  = rdAddrHold;
  assign frameTx = !haveRead ? MISO_RESET :
                   rdAddrHold[0] ? {8'h00, rdData[7:0]} : rdData;

  ssp_crc4 uTxCrc (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .init    (csFall),
    .step    (rise && bitCnt < 5'(FRAME_BITS)),
    .bitIn   (misoOut),
    .poly    (crcPoly),
    .seed    (crcSeed),
    .crc     (txCrc)
  );

  ssp_crc4 uRxCrc (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .init    (csFall),
    .step    (rise && bitCnt < 5'(FRAME_BITS)),
    .bitIn   (mosiS[1]),
    .poly    (crcPoly),
    .seed    (crcSeed),
    .crc     (rxCrc)
  );

  // MISO shifts on falling edge; frame load
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      txShift <= 20'h00000;
    end else if (csFall) begin
      txShift <= {frameTx, 4'h0};
    end else if (fall && bitCnt == 5'(FRAME_BITS)) begin
      txShift <= {txCrc, 16'h0000};
    end else if (fall && bitCnt != 5'h00) begin
      txShift <= {txShift[18:0], 1'b0};
    end
  end

  // Output pin, registered, driven only in SPI mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      misoOut <= 1'b0;
      misoOe  <= 1'b0;
    end else begin
      misoOut <= txShift[19];
      misoOe  <= active && !csS[1];
    end
  end

  logic frameOk, crcBad, extFrame;
  // at least sixteen bits; extended frame
  assign extFrame = bitCnt >= 5'(EXT_BITS);
  assign crcBad  = spi_crc_check_enable && extFrame && (rxShift[3:0] != rxCrc);
  assign frameOk = bitCnt >= 5'(FRAME_BITS) && !crcBad &&
                   (extFrame ? !rxShift[19] : !rxShift[POS_SYNC]);

  logic [15:0] cmdWord;
  assign cmdWord = extFrame ? rxShift[19:4] : rxShift[15:0];

  // act at select rise; one byte per write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrReq      <= '0;
      rdAddrHold <= 6'h00;
      haveRead   <= 1'b0;
      crcErrSet  <= 1'b0;
    end else begin
      wrReq.valid <= 1'b0;
      crcErrSet   <= csRise && crcBad && bitCnt >= 5'(FRAME_BITS);
      if (csRise && frameOk) begin
        if (cmdWord[POS_RW]) begin
          wrReq.valid <= 1'b1;
          wrReq.addr  <= cmdWord[POS_ADDR_HI:POS_ADDR_LO];
          wrReq.data  <= cmdWord[POS_DATA_HI:0];
        end else begin
          rdAddrHold <= cmdWord[POS_ADDR_HI:POS_ADDR_LO];
          haveRead   <= 1'b1;
        end
      end
    end
  end

  AST_GATE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !selS[1] |=> !misoOe) else $error("MISO driven while port deselected");

  AST_ACT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    wrReq.valid |-> $past(csRise)) else $error("Write without select rise");

  AST_CRCERR: assert property (@(posedge sys_clk) disable iff (!arst_n)
    crcErrSet |-> !wrReq.valid) else $error("Write on bad CRC frame");

  AST_LOAD: assert property (@(posedge sys_clk) disable iff (!arst_n)
    csFall |=> txShift[19:4] == $past(frameTx)) else $error("Frame data not loaded");

  AST_ODD: assert property (@(posedge sys_clk) disable iff (!arst_n)
    csFall && haveRead && rdAddrHold[0] |=> txShift[19:12] == 8'h00) else $error("Odd read upper byte set");

  AST_MISO: assert property (@(posedge sys_clk) disable iff (!arst_n)
    1'b1 |=> misoOut == $past(txShift[19])) else $error("MISO not following shifter");

  AST_SHORT: assert property (@(posedge sys_clk) disable iff (!arst_n)
    csRise && bitCnt < 5'(FRAME_BITS) |=> !wrReq.valid) else $error("Short frame acted");

  AST_NOCHK: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !spi_crc_check_enable |=> !crcErrSet) else $error("CRC flagged while disabled");

  sequence sqWrFrameEnd;
    csRise && frameOk && cmdWord[POS_RW];
  endsequence
  sequence sqWrIssued;
    wrReq.valid && wrReq.addr == $past(cmdWord[POS_ADDR_HI:POS_ADDR_LO]) &&
    wrReq.data == $past(cmdWord[POS_DATA_HI:0]);
  endsequence
  AST_WRITE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sqWrFrameEnd |=> sqWrIssued) else $error("Write frame not applied");

  sequence sqRdFrameEnd;
    csRise && frameOk && !cmdWord[POS_RW];
  endsequence
  sequence sqRdCaptured;
    haveRead && !wrReq.valid && rdAddrHold == $past(cmdWord[POS_ADDR_HI:POS_ADDR_LO]);
  endsequence
  AST_READ: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sqRdFrameEnd |=> sqRdCaptured) else $error("Read address not captured");
endmodule : ssp_spi_slave
`default_nettype wire

// *** sim/ssp_master_model.sv ***
/*
  SPI mode 3 master model that drives the slave port pins.
  Assumes a 40 ns sys_clk; SCLK period is 8 cycles (320 ns).
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_master_model (
  // Clock
  input  wire logic sys_clk,
  // Pins
  output logic      sclk,
  output logic      mosi,
  output logic      cs_n,
  input  wire logic miso
);
  // Idle levels
  initial begin
    sclk = 1'b1;
    mosi = 1'b1;
    cs_n = 1'b1;
  end
  // Wait n cycles, then the fixed drive delay
  task automatic hc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : hc
  // One frame of n bits; rx collects MISO
  task automatic xfer(input logic [19:0] tx, input int n, output logic [19:0] rx);
    rx = '0;
    hc(1);
    cs_n = 1'b0;
    hc(4);
    for (int i = n - 1; i >= 0; i--) begin
      sclk = 1'b0;
      mosi = tx[i];
      hc(4);
      sclk = 1'b1;
      rx = {rx[18:0], miso};
      hc(4);
    end
    cs_n = 1'b1;
    // Released line shows the inverse
    mosi = ~mosi;
    hc(8);
  endtask : xfer
endmodule : ssp_master_model
`default_nettype wire

// *** sim/sensor_spi_slave_port_tb.sv ***
/*
  Bench for the SPI slave port: master model on the pins, byte bank behind.
  Assumes the package CRC defaults are wired to the configuration inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module sensor_spi_slave_port_tb;
  import ssp_pkg::*;
  logic        sys_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        selPin = 1'b1;
  logic        chkEn = 1'b0;
  logic        sclk, mosi, csN, misoOut, misoOe, crcErrSet;
  logic [5:0]  rdAddr;
  logic [15:0] rdData;
  ssp_wr_t     wrReq;
  logic [7:0]  mem [64] = '{default: 8'h00};
  logic [19:0] rx;
  int          badCount = 0;
  int          numChecks = 0;
  int          errCnt = 0;
  int          oeCnt = 0;
  int          oeMark;

  always #20 sys_clk = ~sys_clk;

  // Byte bank; odd reads carry junk above the byte
  assign rdData = rdAddr[0] ? {8'hff, mem[rdAddr]} : {mem[rdAddr], mem[rdAddr | 6'h01]};
  always @(posedge sys_clk) begin
    if (wrReq.valid) mem[wrReq.addr] <= wrReq.data;
    if (crcErrSet) errCnt <= errCnt + 1;
    if (!csN && misoOe) oeCnt <= oeCnt + 1;
  end

  // Released MISO shows the inverse of its last bit
  ssp_master_model u_mst (.sys_clk(sys_clk), .sclk(sclk), .mosi(mosi), .cs_n(csN),
    .miso(misoOe ? misoOut : ~misoOut));
  ssp_spi_slave u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .interface_select_pin(selPin), .sclkPin(sclk),
    .mosiPin(mosi), .csPin_n(csN), .misoOut(misoOut), .misoOe(misoOe), .spi_crc_check_enable(chkEn),
    .crcPoly(CRC_POLY_DEF), .crcSeed(CRC_SEED_DEF), .rdAddr(rdAddr), .rdData(rdData), .wrReq(wrReq),
    .crcErrSet(crcErrSet));

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    numChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Serial CRC, MSB first
  function automatic logic [3:0] crc4(input logic [15:0] w);
    logic [3:0] c;
    c = CRC_SEED_DEF;
    for (int i = 15; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ w[i]) ? CRC_POLY_DEF : 4'h0);
    return c;
  endfunction : crc4
  // Frame of 16 bits, or 20 with CRC (bad flips its low bit)
  task automatic sendf(input logic [15:0] w, input logic ext, input logic bad);
    u_mst.xfer(ext ? {w, crc4(w) ^ {3'h0, bad}} : {4'h0, w}, ext ? 20 : 16, rx);
  endtask : sendf

  task automatic t_rw();
    sendf({2'b00, 6'h10, 8'h00}, 1'b0, 1'b0);
    chk(rx, 20'h0);
    sendf({2'b01, 6'h10, 8'ha5}, 1'b0, 1'b0);
    sendf({2'b01, 6'h11, 8'h3c}, 1'b0, 1'b0);
    chk(rx, 20'h0a500);
    chk({mem[16], mem[17]}, 20'ha53c);
    sendf({2'b00, 6'h11, 8'h00}, 1'b0, 1'b0);
    chk(rx, 20'ha53c);
    sendf({2'b00, 6'h24, 8'h00}, 1'b0, 1'b0);
    chk(rx, 20'h0003c);
    sendf({2'b00, 6'h24, 8'h00}, 1'b1, 1'b0);
    chk(rx, {16'h0, crc4(16'h0)});
  endtask : t_rw

  task automatic t_crc();
    chkEn = 1'b1;
    sendf({2'b01, 6'h12, 8'h77}, 1'b1, 1'b1);
    chk({mem[18], 12'(errCnt)}, 20'h00001);
    sendf({2'b01, 6'h12, 8'h77}, 1'b1, 1'b0);
    chk(mem[18], 20'h77);
    sendf({2'b00, 6'h10, 8'h00}, 1'b1, 1'b0);
    chk(rx, {16'h0, crc4(16'h0)});
    sendf({2'b00, 6'h10, 8'h00}, 1'b1, 1'b0);
    chk(rx, {16'ha53c, crc4(16'ha53c)});
    chkEn = 1'b0;
    sendf({2'b01, 6'h13, 8'h55}, 1'b1, 1'b1);
    chk({mem[19], 12'(errCnt)}, 20'h55001);
  endtask : t_crc

  task automatic t_refuse();
    u_mst.xfer({4'h0, 2'b01, 6'h14, 8'h11}, 15, rx);
    sendf({2'b11, 6'h14, 8'h22}, 1'b0, 1'b0);
    chk(mem[20], 20'h0);
    selPin = 1'b0;
    oeMark = oeCnt;
    sendf({2'b01, 6'h14, 8'h33}, 1'b0, 1'b0);
    chk({mem[20], 12'(oeCnt - oeMark)}, 20'h0);
    selPin = 1'b1;
    chk(oeMark > 0, 20'h1);
  endtask : t_refuse

  task automatic t_reset();
    arst_n = 1'b0;
    u_mst.hc(2);
    arst_n = 1'b1;
    u_mst.hc(4);
    sendf({2'b00, 6'h10, 8'h00}, 1'b0, 1'b0);
    chk(rx, 20'h0);
    sendf({2'b00, 6'h10, 8'h00}, 1'b0, 1'b0);
    chk(rx, 20'h0a53c);
  endtask : t_reset

  task automatic conclude();
    if (badCount == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge sys_clk);
    #2 arst_n = 1'b1;
    u_mst.hc(4);
    t_rw();
    t_crc();
    t_refuse();
    t_reset();
    conclude();
  end
  // Hang guard
  initial begin
    #2000000;
    badCount++;
    conclude();
  end
endmodule : sensor_spi_slave_port_tb
`default_nettype wire
